/* File: src/rbm_defs.svh */
// Offsets, field positions, reset values and timing of the register block map
`ifndef RBM_DEFS_SVH
`define RBM_DEFS_SVH

`define RBM_IDX_PULL        6'h0C
`define RBM_IDX_DRIVE       6'h0D
`define RBM_IDX_POSITION    6'h11

`define RBM_POS_FIELD_HI    7
`define RBM_POS_FIELD_LO    3
`define RBM_POS_STOP_BIT    0
`define RBM_PORT_MASK       8'hF3
`define RBM_POS_MASK        8'hF9

`define RBM_PULL_RESET      8'h10
`define RBM_DRIVE_RESET     8'h00
`define RBM_POS_RESET       8'h00

`define RBM_ANSWER_CYCLES   1

`endif

/* File: src/rbm_pkg.sv */
// Types shared by the register block map design
package rbm_pkg;

    typedef enum logic [1:0] {
        RBM_BUS_IDLE = 2'b00,
        RBM_BUS_ACK  = 2'b01
    } rbm_bus_state_t;

endpackage : rbm_pkg

/* File: src/rbm_block_decode.sv */
// Decodes a CPU address against the relocatable register block base
`timescale 1ns/1ps
module rbm_block_decode (
    // CPU address
    input  wire logic [15:0] cpu_addr,
    // Block position field
    input  wire logic [4:0]  pos_field,
    // Decode result
    output logic             hit,
    output logic [9:0]       index
);

    always_comb begin
        // Only the lower 1K of the 2K region holds registers
        hit   = (cpu_addr[15:11] == pos_field) && !cpu_addr[10];
        index = cpu_addr[9:0];
    end

endmodule : rbm_block_decode

/* File: src/rbm_top.sv */
// Register block placement decoder and port pad control registers
//
// Notes on behaviour
// - Block may sit on any 2K boundary; five-bit field holds address bits 15..11.
// - Position field forms the upper five bits of the 16-bit block base.
// - Only the lower 1K of the selected 2K region selects the block.
// - After reset the block sits at its default base address.
// - Position register: field in bits 7..3, stop-in-wait in bit 0, bits 2..1 zero.
// - Software enables port pull-ups and selects reduced output drive.
// - Pull register: K7 J6 H5 E4 B1 A0; bits 3..2 read zero.
// - Drive register: K7 J6 H5 E4 B1 A0; bits 3..2 read zero.
// - Reset enables port E pull-up only; A, B, H, J, K disabled.
// - Reset clears every reduced-drive select: full drive.
// - Ports H and J: one enable each for a pull-up or pull-down load, reset off.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "rbm_defs.svh"
module rbm_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // CPU address decode
    input  wire logic [15:0] cpu_addr,
    output logic             cpu_block_sel,
    output logic [9:0]       cpu_block_index,
    output logic [15:0]      block_base,
    output logic             map_clock_stop_in_wait,
    // Pull controls
    output logic             porta_pull_enable,
    output logic             portb_pull_enable,
    output logic             porte_pull_enable,
    output logic             porth_load_enable,
    output logic             portj_load_enable,
    output logic             portk_pull_enable,
    // Drive controls
    output logic             porta_low_drive,
    output logic             portb_low_drive,
    output logic             porte_low_drive,
    output logic             porth_low_drive,
    output logic             portj_low_drive,
    output logic             portk_low_drive,
    // I2C-shared pins
    input  wire logic [1:0]  i2c_pin_is_output,
    output logic [1:0]       i2c_pull_active
);

    rbm_pkg::rbm_bus_state_t state_ff;
    logic [7:0]              pull_ff;
    logic [7:0]              drive_ff;
    logic [7:0]              pos_ff;
    logic [31:0]             rdata_ff;
    logic                    wait_ff;
    logic                    sel_ff;
    logic [9:0]              index_ff;
    logic [1:0]              i2c_pull_ff;
    logic                    dec_hit;
    logic [9:0]              dec_index;
    logic [5:0]              bus_idx;
    logic                    bus_req;
    logic                    wr_ack;

    assign bus_idx = avs_address[7:2];
    assign bus_req = avs_read || avs_write;
    assign wr_ack  = (state_ff == rbm_pkg::RBM_BUS_ACK) && avs_write && avs_byteenable[0];

    // Read view of a register index; reserved bits read zero, unmapped reads zero
    function automatic logic [7:0] reg_view(input logic [5:0] idx, input logic [7:0] pull,
                                            input logic [7:0] drv, input logic [7:0] pos);
        logic [7:0] val;
        val = 8'h00;
        unique case (idx)
            `RBM_IDX_PULL:     val = pull & `RBM_PORT_MASK;
            `RBM_IDX_DRIVE:    val = drv & `RBM_PORT_MASK;
            `RBM_IDX_POSITION: val = pos & `RBM_POS_MASK;
            default:           val = 8'h00;
        endcase
        return val;
    endfunction : reg_view

    // Bus handshake: one waiting cycle, then the answer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= rbm_pkg::RBM_BUS_IDLE;
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            unique case (state_ff)
                rbm_pkg::RBM_BUS_IDLE: begin
                    if (bus_req) begin
                        state_ff <= rbm_pkg::RBM_BUS_ACK;
                        wait_ff  <= 1'b0;
                        rdata_ff <= {24'h00_0000, reg_view(bus_idx, pull_ff, drive_ff, pos_ff)};
                    end
                end
                rbm_pkg::RBM_BUS_ACK: begin
                    state_ff <= rbm_pkg::RBM_BUS_IDLE;
                    wait_ff  <= 1'b1;
                end
            endcase
        end
    end

    // Pull-up control register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pull_ff <= `RBM_PULL_RESET;
        end else if (wr_ack && bus_idx == `RBM_IDX_PULL) begin
            pull_ff <= avs_writedata[7:0] & `RBM_PORT_MASK;
        end
    end

    // Reduced-drive register; light-load use is up to software
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            drive_ff <= `RBM_DRIVE_RESET;
        end else if (wr_ack && bus_idx == `RBM_IDX_DRIVE) begin
            drive_ff <= avs_writedata[7:0] & `RBM_PORT_MASK;
        end
    end

    // Block position register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pos_ff <= `RBM_POS_RESET;
        end else if (wr_ack && bus_idx == `RBM_IDX_POSITION) begin
            pos_ff <= avs_writedata[7:0] & `RBM_POS_MASK;
        end
    end

    rbm_block_decode u_decode (
        .cpu_addr  (cpu_addr),
        .pos_field (pos_ff[`RBM_POS_FIELD_HI:`RBM_POS_FIELD_LO]),
        .hit       (dec_hit),
        .index     (dec_index)
    );

    // Registered decode of the CPU address
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_ff   <= 1'b0;
            index_ff <= 10'h000;
        end else begin
            sel_ff   <= dec_hit;
            index_ff <= dec_hit ? dec_index : 10'h000;
        end
    end

    // I2C-shared pins pull up whenever they are inputs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            i2c_pull_ff <= 2'h3;
        end else begin
            i2c_pull_ff <= ~i2c_pin_is_output;
        end
    end

    assign avs_readdata           = rdata_ff;
    assign avs_waitrequest        = wait_ff;
    assign cpu_block_sel          = sel_ff;
    assign cpu_block_index        = index_ff;
    assign block_base             = {pos_ff[7:3], 11'h000};
    assign map_clock_stop_in_wait = pos_ff[`RBM_POS_STOP_BIT];
    assign porta_pull_enable      = pull_ff[0];
    assign portb_pull_enable      = pull_ff[1];
    assign porte_pull_enable      = pull_ff[4];
    assign porth_load_enable      = pull_ff[5];
    assign portj_load_enable      = pull_ff[6];
    assign portk_pull_enable      = pull_ff[7];
    assign porta_low_drive        = drive_ff[0];
    assign portb_low_drive        = drive_ff[1];
    assign porte_low_drive        = drive_ff[4];
    assign porth_low_drive        = drive_ff[5];
    assign portj_low_drive        = drive_ff[6];
    assign portk_low_drive        = drive_ff[7];
    assign i2c_pull_active        = i2c_pull_ff;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_sel_matches_base: assert property (
        $past(rst_n) |-> (cpu_block_sel == ($past(cpu_addr[15:11]) == pos_ff[7:3]
            && !$past(cpu_addr[10])) || $past(pos_ff) != pos_ff))
        else $error("block select does not follow position field");

    a_sel_upper_half: assert property (
        cpu_addr[10] |=> !cpu_block_sel)
        else $error("upper half of region selected block");

    a_index_low_bits: assert property (
        (rst_n && cpu_addr[15:11] == pos_ff[7:3] && !cpu_addr[10] && $stable(pos_ff))
            |=> cpu_block_sel && cpu_block_index == $past(cpu_addr[9:0]))
        else $error("block index wrong");

    a_base_from_field: assert property (
        block_base[10:0] == 11'h000 && block_base[15:11] == pos_ff[7:3])
        else $error("block base not aligned to field");

    a_pos_reads_zero: assert property (
        (state_ff == rbm_pkg::RBM_BUS_ACK && avs_read && bus_idx == `RBM_IDX_POSITION)
            |-> avs_readdata[2:1] == 2'b00 && avs_readdata[7:3] == pos_ff[7:3])
        else $error("position register read wrong");

    a_pull_reads_zero: assert property (
        (state_ff == rbm_pkg::RBM_BUS_ACK && avs_read && bus_idx == `RBM_IDX_PULL)
            |-> avs_readdata[7:0] == {pull_ff[7:4], 2'b00, pull_ff[1:0]})
        else $error("pull register read wrong");

    a_drive_reads_zero: assert property (
        (state_ff == rbm_pkg::RBM_BUS_ACK && avs_read && bus_idx == `RBM_IDX_DRIVE)
            |-> avs_readdata[7:0] == {drive_ff[7:4], 2'b00, drive_ff[1:0]})
        else $error("drive register read wrong");

    a_pull_write_lands: assert property (
        (wr_ack && bus_idx == `RBM_IDX_PULL)
            |=> porth_load_enable == $past(avs_writedata[5])
                && porta_pull_enable == $past(avs_writedata[0]))
        else $error("pull write not applied");

    a_answer_one_wait: assert property (
        (rst_n && state_ff == rbm_pkg::RBM_BUS_IDLE && bus_req)
            |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");

    a_i2c_pull_input: assert property (
        $past(rst_n) |-> i2c_pull_active == ~$past(i2c_pin_is_output))
        else $error("i2c pull not tied to direction");

    // Values seen on the first edge after reset is released
    a_reset_pull_state: assert property (
        $rose(rst_n) |-> {portk_pull_enable, porte_pull_enable, portb_pull_enable,
                          porta_pull_enable} == 4'b0100)
        else $error("pull enables not at reset value");

    a_reset_loads_off: assert property (
        $rose(rst_n) |-> !porth_load_enable && !portj_load_enable)
        else $error("port h or j load enabled after reset");

    a_reset_full_drive: assert property (
        $rose(rst_n) |-> {portk_low_drive, portj_low_drive, porth_low_drive, porte_low_drive,
                          portb_low_drive, porta_low_drive} == 6'b000000)
        else $error("reduced drive selected after reset");

    a_reset_base_default: assert property (
        $rose(rst_n) |-> block_base == 16'h0000 && !map_clock_stop_in_wait && avs_waitrequest)
        else $error("block position not at default after reset");

    a_drive_write_lands: assert property (
        (wr_ack && bus_idx == `RBM_IDX_DRIVE)
            |=> {portk_low_drive, portj_low_drive, porth_low_drive, porte_low_drive,
                 portb_low_drive, porta_low_drive}
                == {$past(avs_writedata[7:4]), $past(avs_writedata[1:0])})
        else $error("drive write not applied");

    a_pos_write_lands: assert property (
        (wr_ack && bus_idx == `RBM_IDX_POSITION)
            |=> block_base[15:11] == $past(avs_writedata[7:3])
                && map_clock_stop_in_wait == $past(avs_writedata[0]))
        else $error("position write not applied");

    a_pull_holds: assert property (
        (rst_n && !(wr_ack && bus_idx == `RBM_IDX_PULL))
            |=> $stable({portk_pull_enable, portj_load_enable, porth_load_enable,
                         porte_pull_enable, portb_pull_enable, porta_pull_enable}))
        else $error("pull enables changed without a write");

    a_drive_holds: assert property (
        (rst_n && !(wr_ack && bus_idx == `RBM_IDX_DRIVE))
            |=> $stable({portk_low_drive, portj_low_drive, porth_low_drive,
                         porte_low_drive, portb_low_drive, porta_low_drive}))
        else $error("drive selects changed without a write");

    a_lane_off_ignored: assert property (
        (state_ff == rbm_pkg::RBM_BUS_ACK && avs_write && !avs_byteenable[0])
            |=> $stable(block_base) && $stable(map_clock_stop_in_wait))
        else $error("write without low lane changed position");

    a_read_high_zero: assert property (
        (state_ff == rbm_pkg::RBM_BUS_ACK && avs_read) |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bytes not zero");

    a_unmapped_read_zero: assert property (
        (state_ff == rbm_pkg::RBM_BUS_ACK && avs_read && bus_idx != `RBM_IDX_PULL
            && bus_idx != `RBM_IDX_DRIVE && bus_idx != `RBM_IDX_POSITION)
            |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_sel_off_mismatch: assert property (
        (cpu_addr[15:11] != pos_ff[7:3]) |=> !cpu_block_sel && cpu_block_index == 10'h000)
        else $error("block selected outside its region");

    a_wait_high_idle: assert property (
        (rst_n && state_ff == rbm_pkg::RBM_BUS_IDLE && !bus_req) |=> avs_waitrequest)
        else $error("waitrequest low without a request");

endmodule : rbm_top

/* File: test/rbm_top_bench.sv */
// Self-checking bench for the register block map and pad control registers
`timescale 1ns/1ps
module rbm_top_bench;
    logic        clk_sys, rst_n, avs_read, avs_write, cpu_block_sel, avs_waitrequest;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic [15:0] cpu_addr, block_base;
    logic [9:0]  cpu_block_index;
    logic [1:0]  i2c_pin_is_output, i2c_pull_active;
    logic        map_clock_stop_in_wait;
    logic        pa_pu, pb_pu, pe_pu, ph_ld, pj_ld, pk_pu, pa_rd, pb_rd, pe_rd, ph_rd, pj_rd, pk_rd;
    logic [31:0] rq[$];
    logic [31:0] dq[$];
    logic [7:0]  pos_exp, p_v, d_v;
    logic [31:0] dec_got;
    integer      seed = 32'h2199;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cyc = 0;

    rbm_top i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_addr(cpu_addr),
        .cpu_block_sel(cpu_block_sel), .cpu_block_index(cpu_block_index),
        .block_base(block_base), .map_clock_stop_in_wait(map_clock_stop_in_wait),
        .porta_pull_enable(pa_pu), .portb_pull_enable(pb_pu), .porte_pull_enable(pe_pu),
        .porth_load_enable(ph_ld), .portj_load_enable(pj_ld), .portk_pull_enable(pk_pu),
        .porta_low_drive(pa_rd), .portb_low_drive(pb_rd), .porte_low_drive(pe_rd),
        .porth_low_drive(ph_rd), .portj_low_drive(pj_rd), .portk_low_drive(pk_rd),
        .i2c_pin_is_output(i2c_pin_is_output), .i2c_pull_active(i2c_pull_active));

    assign dec_got = {19'h0, cpu_block_sel, cpu_block_index, i2c_pull_active};

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic cmp_read(input logic [31:0] got, input logic [31:0] exp);
        cmp(got, exp);
    endtask : cmp_read

    task automatic cmp_decode(input logic [31:0] got, input logic [31:0] exp);
        cmp(got, exp);
    endtask : cmp_decode

    task automatic cmp_pad(input logic [31:0] got, input logic [31:0] exp);
        cmp(got, exp);
    endtask : cmp_pad

    // Hang guard: the whole run needs well under 3000 cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    // Read data is taken at the edge where waitrequest is seen low
    always @(posedge clk_sys)
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            cmp_read(avs_readdata, rq.pop_front());

    // Decode and pull results, one cycle after the sampled address
    always @(negedge clk_sys)
        if (dq.size() > 0)
            cmp_decode(dec_got, dq.pop_front());

    task automatic av_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk_sys);
        avs_address    <= a;
        avs_writedata  <= {24'($random(seed)), d};
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : av_wr

    task automatic av_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        rq.push_back({24'h0, exp});
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
    endtask : av_rd

    task automatic chk_all(input logic [7:0] p, input logic [7:0] d, input logic [7:0] pos);
        av_rd(8'h30, p);
        av_rd(8'h34, d);
        av_rd(8'h44, pos);
        cmp_pad({24'h0, pk_pu, pj_ld, ph_ld, pe_pu, 2'b00, pb_pu, pa_pu}, {24'h0, p});
        cmp_pad({24'h0, pk_rd, pj_rd, ph_rd, pe_rd, 2'b00, pb_rd, pa_rd}, {24'h0, d});
        cmp_pad({16'h0, block_base}, {16'h0, pos[7:3], 11'h000});
        cmp_pad({31'h0, map_clock_stop_in_wait}, {31'h0, pos[0]});
    endtask : chk_all

    task automatic dec(input logic [15:0] a);
        logic [1:0] dir;
        dir = 2'($random(seed));
        @(posedge clk_sys);
        cpu_addr          <= a;
        i2c_pin_is_output <= dir;
        @(posedge clk_sys);
        if (a[15:11] == pos_exp[7:3] && !a[10]) dq.push_back({19'h0, 1'b1, a[9:0], ~dir});
        else dq.push_back({19'h0, 1'b0, 10'h000, ~dir});
    endtask : dec

    initial begin
        rst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        cpu_addr = 16'h0000;
        i2c_pin_is_output = 2'b00;
        pos_exp = 8'h00;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk_all(8'h10, 8'h00, 8'h00);
        for (int b = 0; b < 8; b++) begin
            p_v = 8'h01 << b;
            d_v = 8'($random(seed));
            av_wr(8'h30, p_v, 4'h1);
            av_wr(8'h34, d_v, 4'hF);
            chk_all(p_v & 8'hF3, d_v & 8'hF3, pos_exp);
        end
        repeat (6) begin
            p_v = 8'($random(seed));
            av_wr(8'h44, p_v, 4'h1);
            pos_exp = p_v & 8'hF9;
            chk_all(8'h80, d_v & 8'hF3, pos_exp);
            dec({pos_exp[7:3], 1'b0, 10'($random(seed))});
            dec({pos_exp[7:3], 1'b1, 10'($random(seed))});
            dec({pos_exp[7:3], 1'b0, 10'h3FF});
            dec(16'($random(seed)));
        end
        av_wr(8'h30, 8'hFF, 4'h0);
        av_wr(8'h3C, 8'hFF, 4'h1);
        av_rd(8'h3C, 8'h00);
        chk_all(8'h80, d_v & 8'hF3, pos_exp);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        pos_exp = 8'h00;
        chk_all(8'h10, 8'h00, 8'h00);
        dec(16'h0011);
        dec(16'h0811);
        repeat (3) @(posedge clk_sys);
        finish_test();
    end
endmodule : rbm_top_bench
